//--- pfsg_defines.svh
// Purpose: addresses, field positions and reset values of the pin function block
// Assumes: byte addresses on a 32-bit register port
// Notes:   included by the package user files by bare name
`ifndef PFSG_DEFINES_SVH
`define PFSG_DEFINES_SVH

// gpio register group addresses
`define PFSG_ADDR_P0_VAL 32'hE002_8000
`define PFSG_ADDR_P0_SET 32'hE002_8004
`define PFSG_ADDR_P0_DIR 32'hE002_8008
`define PFSG_ADDR_P0_CLR 32'hE002_800C
`define PFSG_ADDR_P1_VAL 32'hE002_8010
`define PFSG_ADDR_P1_SET 32'hE002_8014
`define PFSG_ADDR_P1_DIR 32'hE002_8018
`define PFSG_ADDR_P1_CLR 32'hE002_801C
// function select addresses
`define PFSG_ADDR_SEL1   32'hE002_C004
`define PFSG_ADDR_SEL2   32'hE002_C014

// upper port0 select field positions (low bit of each two-bit field)
`define PFSG_F_P26 20
`define PFSG_F_P27 22
`define PFSG_F_P28 24
`define PFSG_F_P29 26
`define PFSG_F_P30 28
`define PFSG_F_P31 30
// first port0 pin handled by the upper select register
`define PFSG_SEL1_FIRST_PIN 16
// port0 pin with no function in any code
`define PFSG_P0_NO_PIN 24
// port0 output-only pin
`define PFSG_P0_OUT_ONLY 31

// debug/trace select bit positions
`define PFSG_B_DEBUG 2
`define PFSG_B_TRACE 3

// port1 pin groups
`define PFSG_P1_PIN_MASK 32'hFFFF_0000
`define PFSG_P1_TRC_LO   16
`define PFSG_P1_DBG_LO   26
// strap pins sampled at reset
`define PFSG_P1_DBG_STRAP 26
`define PFSG_P1_TRC_STRAP 20

// reset values
`define PFSG_RST_WORD 32'h0000_0000

`endif

//--- pfsg_pkg.sv
// Purpose: types shared by the pin function block
// Assumes: nothing
// Notes:   constants live in pfsg_defines.svh
package pfsg_pkg;

  // two-bit pin function code
  typedef enum logic [1:0] {
    pfsg_fn_primary,
    pfsg_fn_alt1,
    pfsg_fn_alt2,
    pfsg_fn_alt3
  } pfsg_fn_t;

  // pad drive bundle of one port
  typedef struct packed {
    logic [31:0] out;
    logic [31:0] oe;
  } pfsg_pad_t;

  // whole block state
  typedef struct packed {
    logic [31:0] set0;
    logic [31:0] set1;
    logic [31:0] dir0;
    logic [31:0] dir1;
    logic [31:0] sel1;
    logic        dbg;
    logic        trc;
    logic [31:0] rdata;
  } pfsg_state_t;

endpackage

//--- pfsg_top.sv
// Purpose: port0/port1 pin function select and general purpose i/o
// Assumes: register port with read data one cycle after the read strobe
// Notes:   pads are split into input, output and output enable
`timescale 1ns/1ps
`include "pfsg_defines.svh"

module pfsg_top (
  input  wire logic                clk_i,
  input  wire logic                sys_rst_i,
  input  wire logic [31:0]         addr_i,
  input  wire logic [31:0]         wdata_i,
  input  wire logic                we_i,
  input  wire logic                re_i,
  output logic      [31:0]         rdata_o,
  input  wire logic [31:0]         p0_pad_i,
  output pfsg_pkg::pfsg_pad_t      p0_pad_o,
  input  wire logic [31:0]         p1_pad_i,
  output pfsg_pkg::pfsg_pad_t      p1_pad_o,
  output logic      [5:0]          adc0_chan_en_o,
  output logic      [3:0]          tmr0_cap_o,
  input  wire logic [3:1]          tmr0_match_i,
  output logic                     external_interrupt_3_o,
  output logic      [5:0]          dbg_pin_o,
  input  wire logic [5:0]          dbg_out_i,
  input  wire logic [5:0]          dbg_oe_i,
  input  wire logic [9:0]          trc_data_i,
  output logic                     debug_sel_o,
  output logic                     trace_sel_o
);

  pfsg_pkg::pfsg_state_t s_q;
  pfsg_pkg::pfsg_state_t s_d;
  logic [31:0]           gpio0;
  logic [31:0]           gpio1;
  logic [31:0]           o0;
  logic [31:0]           o1;
  pfsg_pkg::pfsg_fn_t    f26;
  pfsg_pkg::pfsg_fn_t    f27;
  pfsg_pkg::pfsg_fn_t    f28;
  pfsg_pkg::pfsg_fn_t    f29;
  pfsg_pkg::pfsg_fn_t    f30;
  pfsg_pkg::pfsg_fn_t    f31;

  // field decode
  assign f26 = pfsg_pkg::pfsg_fn_t'(s_q.sel1[`PFSG_F_P26 +: 2]);
  assign f27 = pfsg_pkg::pfsg_fn_t'(s_q.sel1[`PFSG_F_P27 +: 2]);
  assign f28 = pfsg_pkg::pfsg_fn_t'(s_q.sel1[`PFSG_F_P28 +: 2]);
  assign f29 = pfsg_pkg::pfsg_fn_t'(s_q.sel1[`PFSG_F_P29 +: 2]);
  assign f30 = pfsg_pkg::pfsg_fn_t'(s_q.sel1[`PFSG_F_P30 +: 2]);
  assign f31 = pfsg_pkg::pfsg_fn_t'(s_q.sel1[`PFSG_F_P31 +: 2]);

  // gpio ownership per pin
  always_comb begin
    gpio0 = '1;
    for (int i = `PFSG_SEL1_FIRST_PIN; i < 32; i++) begin
      gpio0[i] = (s_q.sel1[2*(i-`PFSG_SEL1_FIRST_PIN) +: 2] == 2'b00);
    end
    gpio0[`PFSG_P0_NO_PIN] = 1'b0;
    gpio1 = `PFSG_P1_PIN_MASK;
    gpio1[`PFSG_P1_DBG_LO +: 6] = {6{~s_q.dbg}};
    gpio1[`PFSG_P1_TRC_LO +: 10] = {10{~s_q.trc}};
  end

  // pins whose output latch software may steer
  always_comb begin
    o0 = gpio0 & s_q.dir0;
    o0[`PFSG_P0_OUT_ONLY] = gpio0[`PFSG_P0_OUT_ONLY];
    o1 = gpio1 & s_q.dir1;
  end

  // port0 pads and peripheral routing
  always_comb begin
    p0_pad_o.out = s_q.set0 & o0;
    p0_pad_o.oe  = o0;
    adc0_chan_en_o = 6'h00;
    tmr0_cap_o     = 4'h0;
    external_interrupt_3_o        = 1'b0;
    adc0_chan_en_o[5] = (f26 == pfsg_pkg::pfsg_fn_alt1);
    adc0_chan_en_o[0] = (f27 == pfsg_pkg::pfsg_fn_alt1);
    adc0_chan_en_o[1] = (f28 == pfsg_pkg::pfsg_fn_alt1);
    adc0_chan_en_o[2] = (f29 == pfsg_pkg::pfsg_fn_alt1);
    adc0_chan_en_o[3] = (f30 == pfsg_pkg::pfsg_fn_alt1);
    if (f27 == pfsg_pkg::pfsg_fn_alt2) tmr0_cap_o[1] = p0_pad_i[27];
    if (f28 == pfsg_pkg::pfsg_fn_alt2) tmr0_cap_o[2] = p0_pad_i[28];
    if (f29 == pfsg_pkg::pfsg_fn_alt2) tmr0_cap_o[3] = p0_pad_i[29];
    if (f30 == pfsg_pkg::pfsg_fn_alt3) tmr0_cap_o[0] = p0_pad_i[30];
    if (f30 == pfsg_pkg::pfsg_fn_alt2) external_interrupt_3_o = p0_pad_i[30];
    if (f27 == pfsg_pkg::pfsg_fn_alt3) begin
      p0_pad_o.out[27] = tmr0_match_i[1];
      p0_pad_o.oe[27]  = 1'b1;
    end
    if (f28 == pfsg_pkg::pfsg_fn_alt3) begin
      p0_pad_o.out[28] = tmr0_match_i[2];
      p0_pad_o.oe[28]  = 1'b1;
    end
    if (f29 == pfsg_pkg::pfsg_fn_alt3) begin
      p0_pad_o.out[29] = tmr0_match_i[3];
      p0_pad_o.oe[29]  = 1'b1;
    end
  end

  // port1 pads, debug and trace routing
  always_comb begin
    p1_pad_o.out = s_q.set1 & o1;
    p1_pad_o.oe  = o1;
    dbg_pin_o    = 6'h00;
    if (s_q.dbg) begin
      dbg_pin_o = p1_pad_i[`PFSG_P1_DBG_LO +: 6];
      p1_pad_o.out[`PFSG_P1_DBG_LO +: 6] = dbg_out_i & dbg_oe_i;
      p1_pad_o.oe[`PFSG_P1_DBG_LO +: 6]  = dbg_oe_i;
    end
    if (s_q.trc) begin
      p1_pad_o.out[`PFSG_P1_TRC_LO +: 10] = trc_data_i;
      p1_pad_o.oe[`PFSG_P1_TRC_LO +: 10]  = 10'h3FF;
    end
  end

  assign debug_sel_o = s_q.dbg;
  assign trace_sel_o = s_q.trc;
  assign rdata_o     = s_q.rdata;

  // next state: register writes, reads and reset
  always_comb begin
    s_d       = s_q;
    s_d.rdata = `PFSG_RST_WORD;
    if (we_i) begin
      unique case (addr_i)
        `PFSG_ADDR_P0_VAL: s_d.set0 = (s_q.set0 & ~o0) | (wdata_i & o0);
        `PFSG_ADDR_P0_SET: s_d.set0 = s_q.set0 | (wdata_i & o0);
        `PFSG_ADDR_P0_DIR: s_d.dir0 = wdata_i;
        `PFSG_ADDR_P0_CLR: s_d.set0 = s_q.set0 & ~(wdata_i & o0);
        `PFSG_ADDR_P1_VAL: s_d.set1 = (s_q.set1 & ~o1) | (wdata_i & o1);
        `PFSG_ADDR_P1_SET: s_d.set1 = s_q.set1 | (wdata_i & o1);
        `PFSG_ADDR_P1_DIR: s_d.dir1 = wdata_i & `PFSG_P1_PIN_MASK;
        `PFSG_ADDR_P1_CLR: s_d.set1 = s_q.set1 & ~(wdata_i & o1);
        `PFSG_ADDR_SEL1:   s_d.sel1 = wdata_i;
        `PFSG_ADDR_SEL2: begin
          s_d.dbg = wdata_i[`PFSG_B_DEBUG];
          s_d.trc = wdata_i[`PFSG_B_TRACE];
        end
        default: ;
      endcase
    end
    if (re_i) begin
      unique case (addr_i)
        `PFSG_ADDR_P0_VAL: s_d.rdata = p0_pad_i & gpio0;
        `PFSG_ADDR_P0_SET: s_d.rdata = s_q.set0;
        `PFSG_ADDR_P0_DIR: s_d.rdata = s_q.dir0;
        `PFSG_ADDR_P1_VAL: s_d.rdata = p1_pad_i & gpio1;
        `PFSG_ADDR_P1_SET: s_d.rdata = s_q.set1;
        `PFSG_ADDR_P1_DIR: s_d.rdata = s_q.dir1;
        `PFSG_ADDR_SEL1:   s_d.rdata = s_q.sel1;
        `PFSG_ADDR_SEL2: begin
          s_d.rdata[`PFSG_B_DEBUG] = s_q.dbg;
          s_d.rdata[`PFSG_B_TRACE] = s_q.trc;
        end
        default: ;
      endcase
    end
    if (sys_rst_i) begin
      s_d.set0  = `PFSG_RST_WORD;
      s_d.set1  = `PFSG_RST_WORD;
      s_d.dir0  = `PFSG_RST_WORD;
      s_d.dir1  = `PFSG_RST_WORD;
      s_d.sel1  = `PFSG_RST_WORD;
      s_d.rdata = `PFSG_RST_WORD;
      s_d.dbg   = p1_pad_i[`PFSG_P1_DBG_STRAP];
      s_d.trc   = p1_pad_i[`PFSG_P1_TRC_STRAP];
    end
  end

  always_ff @(posedge clk_i) begin
    s_q <= s_d;
  end

  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  chk_p26_adc_route: assert property (
    (s_q.sel1[21:20] == 2'b01) |-> (adc0_chan_en_o[5] && !p0_pad_o.oe[26]))
    else $error("pin 26 adc routing wrong");

  chk_p28_match_drive: assert property (
    (s_q.sel1[25:24] == 2'b11) |-> (p0_pad_o.oe[28] && p0_pad_o.out[28] == tmr0_match_i[2]))
    else $error("pin 28 match drive wrong");

  chk_p29_capture_in: assert property (
    (s_q.sel1[27:26] == 2'b10) |-> (tmr0_cap_o[3] == p0_pad_i[29] && !p0_pad_o.oe[29]))
    else $error("pin 29 capture routing wrong");

  chk_p30_eint_route: assert property (
    (s_q.sel1[29:28] == 2'b10) |-> (external_interrupt_3_o == p0_pad_i[30] && tmr0_cap_o[0] == 1'b0))
    else $error("pin 30 interrupt routing wrong");

  chk_p31_output_only: assert property (
    p0_pad_o.oe[31] == (s_q.sel1[31:30] == 2'b00))
    else $error("pin 31 enable wrong");

  chk_debug_pin_route: assert property (
    s_q.dbg |-> (p1_pad_o.oe[31:26] == dbg_oe_i))
    else $error("debug pins not handed over");

  chk_trace_pin_route: assert property (
    s_q.trc |-> (p1_pad_o.oe[25:16] == 10'h3FF && p1_pad_o.out[25:16] == trc_data_i))
    else $error("trace pins not handed over");

  chk_set_drives_high: assert property (
    (we_i && addr_i == `PFSG_ADDR_P0_SET) |=>
      ((p0_pad_o.out & $past(wdata_i & o0)) == $past(wdata_i & o0)))
    else $error("set write did not drive high");

  chk_clear_drives_low: assert property (
    (we_i && addr_i == `PFSG_ADDR_P0_CLR) |=> ((s_q.set0 & $past(wdata_i & o0)) == 32'h0000_0000))
    else $error("clear write did not clear");

  chk_dir_after_reset: assert property (
    $fell(sys_rst_i) |-> (s_q.dir0 == 32'h0000_0000 && p1_pad_o.oe[15:0] == 16'h0000))
    else $error("direction not input after reset");

  chk_pin_read_value: assert property (
    (re_i && addr_i == `PFSG_ADDR_P0_VAL) |=> (rdata_o == $past(p0_pad_i & gpio0)))
    else $error("pin value read wrong");

  chk_port1_low_idle: assert property (
    (p1_pad_o.oe[15:0] == 16'h0000) && (s_q.dir1[15:0] == 16'h0000))
    else $error("port1 low pins driven");

  chk_p27_capture_in: assert property (
    (s_q.sel1[23:22] == 2'b10) |-> (tmr0_cap_o[1] == p0_pad_i[27] && !p0_pad_o.oe[27]))
    else $error("pin 27 capture routing wrong");

  chk_p27_match_drive: assert property (
    (s_q.sel1[23:22] == 2'b11) |-> (p0_pad_o.oe[27] && p0_pad_o.out[27] == tmr0_match_i[1]))
    else $error("pin 27 match drive wrong");

  chk_p27_adc_route: assert property (
    (s_q.sel1[23:22] == 2'b01) |-> (adc0_chan_en_o[0] && !p0_pad_o.oe[27]))
    else $error("pin 27 adc routing wrong");

  chk_p26_reserved_idle: assert property (
    s_q.sel1[21] |-> (!p0_pad_o.oe[26] && !adc0_chan_en_o[5]))
    else $error("pin 26 reserved code not idle");

  chk_p28_adc_route: assert property (
    (s_q.sel1[25:24] == 2'b01) |-> (adc0_chan_en_o[1] && !p0_pad_o.oe[28]))
    else $error("pin 28 adc routing wrong");

  chk_p28_capture_in: assert property (
    (s_q.sel1[25:24] == 2'b10) |-> (tmr0_cap_o[2] == p0_pad_i[28] && !p0_pad_o.oe[28]))
    else $error("pin 28 capture routing wrong");

  chk_p29_adc_route: assert property (
    (s_q.sel1[27:26] == 2'b01) |-> (adc0_chan_en_o[2] && !p0_pad_o.oe[29]))
    else $error("pin 29 adc routing wrong");

  chk_p29_match_drive: assert property (
    (s_q.sel1[27:26] == 2'b11) |-> (p0_pad_o.oe[29] && p0_pad_o.out[29] == tmr0_match_i[3]))
    else $error("pin 29 match drive wrong");

  chk_p30_adc_route: assert property (
    (s_q.sel1[29:28] == 2'b01) |-> (adc0_chan_en_o[3] && !p0_pad_o.oe[30]))
    else $error("pin 30 adc routing wrong");

  chk_p30_capture_in: assert property (
    (s_q.sel1[29:28] == 2'b11) |-> (tmr0_cap_o[0] == p0_pad_i[30] && !external_interrupt_3_o))
    else $error("pin 30 capture routing wrong");

  chk_p31_drive_latch: assert property (
    (s_q.sel1[31:30] == 2'b00) |-> (p0_pad_o.out[31] == s_q.set0[31]))
    else $error("pin 31 output not from latch");

  chk_debug_off_idle: assert property (
    !s_q.dbg |-> (dbg_pin_o == 6'h00 && p1_pad_o.oe[31:26] == s_q.dir1[31:26]))
    else $error("debug pins not gpio");

  chk_trace_off_gpio: assert property (
    !s_q.trc |-> (p1_pad_o.oe[25:16] == s_q.dir1[25:16]))
    else $error("trace pins not gpio");

  chk_sel2_reserved_zero: assert property (
    (re_i && addr_i == `PFSG_ADDR_SEL2) |=> (rdata_o[31:4] == 28'h000_0000 && rdata_o[1:0] == 2'h0))
    else $error("reserved select bits not zero");

  chk_sel_reset_zero: assert property (
    $fell(sys_rst_i) |-> (s_q.sel1 == 32'h0000_0000))
    else $error("select fields not zero after reset");

  chk_p24_never_drive: assert property (
    !p0_pad_o.oe[24])
    else $error("pin 24 driven");

  chk_low_dir_enable: assert property (
    p0_pad_o.oe[15:0] == s_q.dir0[15:0])
    else $error("low port0 direction not applied");

  chk_p1_read_value: assert property (
    (re_i && addr_i == `PFSG_ADDR_P1_VAL) |=> (rdata_o == $past(p1_pad_i & gpio1)))
    else $error("port1 pin value read wrong");

  chk_clr_reads_zero: assert property (
    (re_i && addr_i == `PFSG_ADDR_P0_CLR) |=> (rdata_o == 32'h0000_0000))
    else $error("clear register not write-only");

  chk_p1_set_lands: assert property (
    (we_i && addr_i == `PFSG_ADDR_P1_SET) |=>
      ((s_q.set1 & $past(wdata_i & o1)) == $past(wdata_i & o1)))
    else $error("port1 set write did not land");

  chk_strap_load: assert property (
    $fell(sys_rst_i) |-> (s_q.dbg == $past(p1_pad_i[`PFSG_P1_DBG_STRAP])
      && s_q.trc == $past(p1_pad_i[`PFSG_P1_TRC_STRAP])))
    else $error("select straps not loaded");

  chk_set_ignores_input: assert property (
    (we_i && addr_i == `PFSG_ADDR_P0_SET) |=>
      ((s_q.set0 & ~$past(o0)) == ($past(s_q.set0) & ~$past(o0))))
    else $error("set write touched non-output pin");

  chk_clear_ignores_input: assert property (
    (we_i && addr_i == `PFSG_ADDR_P0_CLR) |=>
      ((s_q.set0 & ~$past(o0)) == ($past(s_q.set0) & ~$past(o0))))
    else $error("clear write touched non-output pin");

  chk_clear_pad_low: assert property (
    (we_i && addr_i == `PFSG_ADDR_P0_CLR) |=> ((p0_pad_o.out & $past(wdata_i & o0)) == 32'h0))
    else $error("clear write did not drive low");

endmodule

//--- pfsg_top_tb_top.sv
// Purpose: self-checking bench of the pin function and gpio block
// Assumes: bus and pads driven by non-blocking assignment after rising edges
// Notes:   read data and pin observations are matched against a queue of notes
`timescale 1ns/1ps
`include "pfsg_defines.svh"

module pfsg_top_tb_top;
  logic                clk_i;
  logic                sys_rst_i;
  logic                we_i;
  logic                re_i;
  logic                pr;
  logic                rd_v;
  logic [31:0]         addr_i;
  logic [31:0]         wdata_i;
  logic [31:0]         rdata_o;
  logic [31:0]         p0_pad_i;
  logic [31:0]         p1_pad_i;
  logic [31:0]         nz;
  logic [31:0]         seed;
  logic [31:0]         r;
  logic [31:0]         e;
  logic [31:0]         m_s2;
  logic [31:0]         m_set [2];
  logic [31:0]         m_dir [2];
  logic [31:0]         q [$];
  pfsg_pkg::pfsg_pad_t p0_pad_o;
  pfsg_pkg::pfsg_pad_t p1_pad_o;
  logic [5:0]          adc0_chan_en_o;
  logic [5:0]          dbg_pin_o;
  logic [5:0]          dbg_out_i;
  logic [5:0]          dbg_oe_i;
  logic [3:0]          tmr0_cap_o;
  logic [3:1]          tmr0_match_i;
  logic [9:0]          trc_data_i;
  logic                external_interrupt_3_o;
  logic                debug_sel_o;
  logic                trace_sel_o;
  logic [27:0]         obs;
  int                  miscompares;
  int                  total_checks;

  pfsg_top DUT (.clk_i, .sys_rst_i, .addr_i, .wdata_i, .we_i, .re_i, .rdata_o, .p0_pad_i,
    .p0_pad_o, .p1_pad_i, .p1_pad_o, .adc0_chan_en_o, .tmr0_cap_o, .tmr0_match_i, .external_interrupt_3_o,
    .dbg_pin_o, .dbg_out_i, .dbg_oe_i, .trc_data_i, .debug_sel_o, .trace_sel_o);

  // pad wire level: driven value where enabled, bench noise elsewhere
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      p0_pad_i[i] = (p0_pad_o.oe[i] === 1'b1) ? p0_pad_o.out[i] : nz[i];
      p1_pad_i[i] = (p1_pad_o.oe[i] === 1'b1) ? p1_pad_o.out[i] : nz[i];
    end
  end
  assign obs = {dbg_pin_o, p0_pad_o.oe[31:26], p0_pad_o.out[29:27] & p0_pad_o.oe[29:27],
    adc0_chan_en_o,
    tmr0_cap_o, external_interrupt_3_o, debug_sel_o, trace_sel_o};

  function automatic logic [31:0] rng();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [31:0] ba(int p);
    return `PFSG_ADDR_P0_VAL + 32'(p) * 32'h0000_0010;
  endfunction
  function automatic logic [31:0] gm(int p);
    if (p == 0) return 32'hFEFF_FFFF;
    return 32'hFFFF_0000 & ~(m_s2[2] ? 32'hFC00_0000 : 32'h0000_0000)
      & ~(m_s2[3] ? 32'h03FF_0000 : 32'h0000_0000);
  endfunction
  function automatic logic [31:0] om(int p);
    return (m_dir[p] | (p == 0 ? 32'h8000_0000 : 32'h0000_0000)) & gm(p);
  endfunction
  function automatic logic [31:0] pv(int p);
    return ((m_set[p] & om(p)) | (nz & ~om(p))) & gm(p);
  endfunction

  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic drv(input logic w, rr, p, input logic [31:0] a, d);
    we_i <= w;
    re_i <= rr;
    pr <= p;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [31:0] a, d);
    drv(1'b1, 1'b0, 1'b0, a, d);
  endtask
  task automatic rd(input logic [31:0] a, x);
    q.push_back(x);
    drv(1'b0, 1'b1, 1'b0, a, 32'h0000_0000);
  endtask
  task automatic probe(input logic [27:0] x);
    q.push_back({4'h0, x});
    drv(1'b0, 1'b0, 1'b1, 32'h0000_0000, 32'h0000_0000);
  endtask
  task automatic setw(int p, input logic [31:0] d);
    m_set[p] = m_set[p] | (d & om(p));
    wr(ba(p) + 32'h0000_0004, d);
  endtask
  task automatic clrw(int p, input logic [31:0] d);
    m_set[p] = m_set[p] & ~(d & om(p));
    wr(ba(p) + 32'h0000_000C, d);
  endtask
  task automatic dirw(int p, input logic [31:0] d);
    m_dir[p] = (p == 0) ? d : d & 32'hFFFF_0000;
    wr(ba(p) + 32'h0000_0008, d);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // monitor: oldest note against read data or pin observation
  always @(posedge clk_i) begin
    if (rd_v) begin
      e = q.pop_front();
      check("read data", rdata_o, e);
    end
    if (pr) begin
      e = q.pop_front();
      check("pin functions", {4'h0, obs}, e);
    end
    rd_v <= re_i;
  end

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  initial begin
    repeat (100000) @(posedge clk_i);
    miscompares++;
    close_out();
  end

  initial begin
    sys_rst_i = 1'b1;
    {we_i, re_i, pr, rd_v, addr_i, wdata_i, nz, m_s2} = '0;
    {dbg_out_i, dbg_oe_i, trc_data_i, tmr0_match_i} = '0;
    seed = 32'heed3844e;
    m_set = '{2{32'h0000_0000}};
    m_dir = '{2{32'h0000_0000}};
    repeat (12) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    drv(1'b0, 1'b0, 1'b0, 32'h0000_0000, 32'h0000_0000);
    // reset values, write-only clear, unmapped place
    foreach (m_set[p]) begin
      for (int k = 4; k < 16; k += 4) rd(ba(p) + 32'(k), 32'h0000_0000);
    end
    rd(`PFSG_ADDR_SEL1, 32'h0000_0000);
    rd(`PFSG_ADDR_SEL2, 32'h0000_0000);
    rd(32'hE002_8020, 32'h0000_0000);
    // random gpio traffic on both ports
    for (int i = 0; i < 6; i++) begin
      for (int p = 0; p < 2; p++) begin
        nz <= rng();
        dirw(p, rng());
        setw(p, rng());
        clrw(p, rng());
        setw(p, 32'h8001_0000);
        clrw(p, 32'h0001_0000);
        rd(ba(p) + 32'h0000_0008, m_dir[p]);
        rd(ba(p) + 32'h0000_0004, m_set[p]);
        rd(ba(p), pv(p));
      end
    end
    // every code on the upper port0 fields
    dirw(0, 32'h0000_0000);
    for (int c = 0; c < 4; c++) begin
      nz <= rng();
      r = rng();
      tmr0_match_i <= r[2:0];
      wr(`PFSG_ADDR_SEL1, {{6{2'(c)}}, 20'h0_0000});
      rd(`PFSG_ADDR_SEL1, {{6{2'(c)}}, 20'h0_0000});
      probe({6'h00, c == 0 ? 6'h20 : c == 3 ? 6'h0E : 6'h00, c == 3 ? r[2:0] : 3'h0,
        c == 1 ? 6'h2F : 6'h00, c == 2 ? {nz[29:27], 1'b0} : c == 3 ? {3'h0, nz[30]} : 4'h0,
        c == 2 ? nz[30] : 1'b0, 2'h0});
    end
    wr(`PFSG_ADDR_SEL1, 32'h0000_0000);
    // debug and trace groups taken away from gpio
    dbg_oe_i <= 6'h15;
    dirw(1, 32'hFFFF_0000);
    for (int b = 1; b < 4; b++) begin
      m_s2 = {28'h000_0000, 2'(b), 2'h0};
      wr(`PFSG_ADDR_SEL2, m_s2);
      rd(`PFSG_ADDR_SEL2, m_s2);
      probe({b[0] ? (nz[31:26] & 6'h2A) : 6'h00, 6'h20, 14'h0000, 1'(b), 1'(b >> 1)});
      clrw(1, 32'hFFFF_0000);
      setw(1, 32'hA5C3_0000);
      rd(ba(1), pv(1));
      rd(ba(1) + 32'h0000_0004, m_set[1]);
    end
    // second reset with both straps high
    nz <= 32'hFFFF_FFFF;
    trc_data_i <= 10'h3FF;
    dbg_out_i <= 6'h3F;
    sys_rst_i <= 1'b1;
    repeat (3) drv(1'b0, 1'b0, 1'b0, 32'h0000_0000, 32'h0000_0000);
    sys_rst_i <= 1'b0;
    drv(1'b0, 1'b0, 1'b0, 32'h0000_0000, 32'h0000_0000);
    rd(`PFSG_ADDR_SEL2, 32'h0000_000C);
    probe({6'h3F, 6'h20, 14'h0000, 2'h3});
    rd(ba(1) + 32'h0000_0008, 32'h0000_0000);
    repeat (3) drv(1'b0, 1'b0, 1'b0, 32'h0000_0000, 32'h0000_0000);
    if (q.size() != 0) miscompares++;
    close_out();
  end
endmodule
